/* hw/mies_core.sv */
/*
  Execution unit for a subset of an 8-bit core: increment-and-skip, software
  interrupt, OR with literal, OR with file register, page store, page load
  and long jump. Holds accumulator, zero flag and program counter.
  Assumes the decoder presents an instruction with its file-register read
  data in the same cycle, and honours O_READY and O_SKIP.
*/
`timescale 1ns/1ps
module mies_core
  import mies_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_INSTR_VALID,
  input wire mies_instr_type I_INSTR,
  input wire logic [7:0] I_FILE_RDATA,
  input wire logic [7:0] I_PAGE_RDATA,
  output logic O_READY,
  output logic [7:0] O_ACC,
  output logic O_ZERO,
  output logic [10:0] O_PC,
  output mies_file_wr_type O_FILE_WR,
  output mies_page_wr_type O_PAGE_WR,
  output logic O_STACK_PUSH,
  output logic [10:0] O_STACK_DATA,
  output logic O_SKIP
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mies_state_type state_ff;
  mies_state_type nxt_state;
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic zero_ff;
  logic nxt_zero;
  logic [10:0] pc_ff;
  logic [10:0] nxt_pc;
  mies_file_wr_type file_wr_ff;
  mies_file_wr_type nxt_file_wr;
  mies_page_wr_type page_wr_ff;
  mies_page_wr_type nxt_page_wr;
  logic push_ff;
  logic [10:0] push_data_ff;
  logic skip_ff;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire ready = (state_ff == ST_RUN);
  // Offers made while stalled are ignored, not queued
  wire take = I_INSTR_VALID && ready;
  wire is_inc = take && (I_INSTR.op == INC_SKIP_ZERO_OP);
  wire is_int = take && (I_INSTR.op == SOFT_INT_OP);
  wire is_orl = take && (I_INSTR.op == OR_LITERAL_OP);
  wire is_orf = take && (I_INSTR.op == OR_FILE_REG_OP);
  wire is_store = take && (I_INSTR.op == PAGE_STORE_OP);
  wire is_load = take && (I_INSTR.op == PAGE_LOAD_OP);
  wire is_jump = take && (I_INSTR.op == LONG_JUMP_OP);

  wire [7:0] inc_res = 8'(I_FILE_RDATA + MIES_ONE);
  wire [7:0] orl_res = acc_ff | I_INSTR.literal;
  wire [7:0] orf_res = acc_ff | I_FILE_RDATA;
  wire inc_zero = (inc_res == MIES_ZERO_BYTE);
  wire do_skip = is_inc && inc_zero;
  wire [10:0] pc_next_seq = 11'(pc_ff + MIES_PC_STEP);

  // ------------------------------------------------------------
  // Next-state selection
  // ------------------------------------------------------------
  // Accumulator targets
  assign nxt_acc = is_orl ? orl_res :
                   (is_orf && !I_INSTR.dest) ? orf_res :
                   (is_inc && !I_INSTR.dest) ? inc_res :
                   is_load ? I_PAGE_RDATA : acc_ff;
  assign nxt_zero = is_orl ? (orl_res == MIES_ZERO_BYTE) :
                    is_orf ? (orf_res == MIES_ZERO_BYTE) : zero_ff;
  assign nxt_pc = is_jump ? I_INSTR.target :
                  is_int ? MIES_INT_VECTOR :
                  do_skip ? 11'(pc_ff + MIES_PC_SKIP_STEP) :
                  take ? pc_next_seq : pc_ff;
  assign nxt_file_wr = '{
    we: (is_orf || is_inc) && I_INSTR.dest,
    addr: I_INSTR.file_addr,
    data: is_inc ? inc_res : orf_res
  };
  assign nxt_page_wr = '{
    we: is_store,
    addr: I_INSTR.page_addr,
    data: acc_ff
  };
  // Stall cycles as no-operation
  // A stall counts down with nothing taken, so O_READY stays low meanwhile
  assign nxt_wait = is_int ? MIES_INT_STALL :
                    is_jump ? MIES_JUMP_STALL :
                    do_skip ? MIES_SKIP_STALL :
                    take ? MIES_NO_STALL :
                    (wait_ff != MIES_NO_STALL) ? 2'(wait_ff - MIES_STALL_STEP) :
                    MIES_NO_STALL;
  assign nxt_state = (nxt_wait != MIES_NO_STALL) ? ST_WAIT : ST_RUN;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      state_ff <= ST_RUN;
      wait_ff <= MIES_NO_STALL;
      acc_ff <= MIES_ACC_RESET;
      zero_ff <= MIES_ZERO_RESET;
      pc_ff <= MIES_PC_RESET;
      file_wr_ff <= '0;
      page_wr_ff <= '0;
      push_ff <= 1'b0;
      push_data_ff <= MIES_PC_RESET;
      skip_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      pc_ff <= nxt_pc;
      file_wr_ff <= nxt_file_wr;
      page_wr_ff <= nxt_page_wr;
      push_ff <= is_int;
      push_data_ff <= pc_next_seq;
      skip_ff <= do_skip;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign O_READY = ready;
  assign O_ACC = acc_ff;
  assign O_ZERO = zero_ff;
  assign O_PC = pc_ff;
  assign O_FILE_WR = file_wr_ff;
  assign O_PAGE_WR = page_wr_ff;
  assign O_STACK_PUSH = push_ff;
  assign O_STACK_DATA = push_data_ff;
  assign O_SKIP = skip_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking mies_cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  a_int_push_vector: assert property (
    is_int |=> O_STACK_PUSH && O_PC == MIES_INT_VECTOR
      && O_STACK_DATA == 11'($past(pc_ff) + MIES_PC_STEP))
    else $error("software interrupt push or vector wrong");
  a_int_three_cyc: assert property (
    is_int |=> !O_READY ##1 !O_READY ##1 O_READY)
    else $error("software interrupt not three cycles");
  a_or_literal_acc: assert property (
    is_orl |=> O_ACC == ($past(acc_ff) | $past(I_INSTR.literal)) && O_READY)
    else $error("or literal result wrong");
  a_or_file_dest: assert property (
    is_orf && I_INSTR.dest |=> O_FILE_WR.we
      && O_FILE_WR.data == ($past(acc_ff) | $past(I_FILE_RDATA))
      && O_ACC == $past(acc_ff))
    else $error("or file register write-back wrong");
  a_page_store_copy: assert property (
    is_store |=> O_PAGE_WR.we && O_PAGE_WR.data == $past(acc_ff) && $stable(O_ZERO))
    else $error("page store wrong");
  a_page_load_copy: assert property (
    is_load |=> O_ACC == $past(I_PAGE_RDATA) && $stable(O_ZERO) && !O_PAGE_WR.we)
    else $error("page load wrong");
  a_jump_two_cyc: assert property (
    is_jump |=> O_PC == $past(I_INSTR.target) && !O_READY && $stable(O_ZERO) ##1 O_READY)
    else $error("long jump wrong");
  a_skip_nop_cyc: assert property (
    do_skip |=> O_SKIP && !O_READY ##1 O_READY && $stable(O_PC))
    else $error("skip not a single no-operation cycle");
  a_skip_pc_step: assert property (
    do_skip |=> O_PC == 11'($past(pc_ff) + MIES_PC_SKIP_STEP))
    else $error("skip did not pass the following instruction");
  a_zero_flag_val: assert property (
    is_orl || is_orf |=> O_ZERO == ($past(is_orl) ? ($past(orl_res) == MIES_ZERO_BYTE)
      : ($past(orf_res) == MIES_ZERO_BYTE)))
    else $error("zero flag wrong");
  a_or_file_acc: assert property (
    is_orf && !I_INSTR.dest |=> O_ACC == ($past(acc_ff) | $past(I_FILE_RDATA)) && !O_FILE_WR.we)
    else $error("or file register accumulator target wrong");
  a_store_keeps_acc: assert property (
    is_store |=> $stable(O_ACC) && O_PAGE_WR.addr == $past(I_INSTR.page_addr))
    else $error("page store changed accumulator or address");
  a_inc_no_skip: assert property (
    is_inc && !inc_zero |=> !O_SKIP && O_READY && O_PC == 11'($past(pc_ff) + MIES_PC_STEP))
    else $error("non-zero increment skipped");
  a_stall_no_take: assert property (
    !O_READY |=> $stable(O_ACC) && $stable(O_ZERO) && $stable(O_PC) && !O_STACK_PUSH
      && !O_FILE_WR.we && !O_PAGE_WR.we)
    else $error("stall cycle was not a no-operation");
  a_int_keeps_acc: assert property (
    is_int |=> $stable(O_ACC) && $stable(O_ZERO) && !O_SKIP)
    else $error("software interrupt changed accumulator or flag");

endmodule

/* hw/mies_pkg.sv */
/*
  Constants, operation codes and carrier types for the subset execution unit.
  Assumes a single core clock and a decoder that presents one decoded
  instruction at a time.
*/
package mies_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int MIES_DATA_W = 8;
  localparam int MIES_FILE_AW = 6;
  localparam int MIES_PAGE_AW = 4;
  localparam int MIES_PC_W = 11;
  localparam int MIES_WAIT_W = 2;

  // ------------------------------------------------------------
  // Reset values and fixed addresses
  // ------------------------------------------------------------
  localparam logic [7:0] MIES_ACC_RESET = 8'h00;
  localparam logic MIES_ZERO_RESET = 1'b0;
  localparam logic [10:0] MIES_PC_RESET = 11'h000;
  localparam logic [10:0] MIES_INT_VECTOR = 11'h001;
  localparam logic [10:0] MIES_PC_STEP = 11'h001;
  localparam logic [10:0] MIES_PC_SKIP_STEP = 11'h002;
  localparam logic [7:0] MIES_ONE = 8'h01;
  localparam logic [7:0] MIES_ZERO_BYTE = 8'h00;

  // ------------------------------------------------------------
  // Cycle counts, and the extra stall cycles derived from them
  // ------------------------------------------------------------
  localparam int MIES_INT_CYCLES = 3;
  localparam int MIES_JUMP_CYCLES = 2;
  localparam int MIES_SKIP_CYCLES = 2;
  localparam logic [1:0] MIES_INT_STALL = 2'(MIES_INT_CYCLES - 1);
  localparam logic [1:0] MIES_JUMP_STALL = 2'(MIES_JUMP_CYCLES - 1);
  localparam logic [1:0] MIES_SKIP_STALL = 2'(MIES_SKIP_CYCLES - 1);
  localparam logic [1:0] MIES_NO_STALL = 2'h0;
  localparam logic [1:0] MIES_STALL_STEP = 2'h1;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    NOP_OP,
    INC_SKIP_ZERO_OP,
    SOFT_INT_OP,
    OR_LITERAL_OP,
    OR_FILE_REG_OP,
    PAGE_STORE_OP,
    PAGE_LOAD_OP,
    LONG_JUMP_OP
  } mies_op_type;

  typedef struct packed {
    mies_op_type op;
    logic [7:0] literal;
    logic [5:0] file_addr;
    logic dest;
    logic [3:0] page_addr;
    logic [10:0] target;
  } mies_instr_type;

  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [7:0] data;
  } mies_file_wr_type;

  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] data;
  } mies_page_wr_type;

  typedef enum logic {
    ST_RUN,
    ST_WAIT
  } mies_state_type;
endpackage

/* test/test_mies_core.sv */
/*
  Self-checking bench for the subset execution unit: directed and seeded
  random instructions, with expected results queued by the driver.
  Assumes the design's own assertions and a 20 MHz core clock.
*/
`timescale 1ns/1ps
module test_mies_core
  import mies_pkg::*;
;
  typedef struct packed {
    logic [7:0] acc;
    logic z;
    logic [10:0] pc;
    logic rdy;
    mies_file_wr_type fw;
    mies_page_wr_type pw;
    logic push;
    logic [10:0] sd;
    logic skip;
  } mies_exp_type;

  logic mclk, rst, instr_valid, ready, zero, stack_push, skip, tk;
  mies_instr_type instr;
  logic [7:0] file_rdata, page_rdata, acc, acc_m;
  logic [10:0] pc, stack_data, pc_m;
  logic z_m;
  mies_file_wr_type file_wr;
  mies_page_wr_type page_wr;
  mies_exp_type exp_q[$];
  mies_exp_type e, w;
  int n_fail = 0;
  int samples_checked = 0;

  mies_core uut (.I_MCLK(mclk), .I_RST(rst), .I_INSTR_VALID(instr_valid), .I_INSTR(instr),
    .I_FILE_RDATA(file_rdata), .I_PAGE_RDATA(page_rdata), .O_READY(ready), .O_ACC(acc),
    .O_ZERO(zero), .O_PC(pc), .O_FILE_WR(file_wr), .O_PAGE_WR(page_wr),
    .O_STACK_PUSH(stack_push), .O_STACK_DATA(stack_data), .O_SKIP(skip));

  // ------------------------------------------------------------
  // Clock, checks and closing
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Driver: predicts the result, then presents the instruction
  // ------------------------------------------------------------
  task automatic exec(input mies_instr_type ins, input logic [7:0] fd, input logic [7:0] pd);
    logic [7:0] r;
    int n;
    e = '0;
    e.acc = acc_m;
    e.z = z_m;
    e.pc = pc_m + MIES_PC_STEP;
    e.rdy = 1'b1;
    r = (ins.op == INC_SKIP_ZERO_OP) ? fd + MIES_ONE : acc_m | fd;
    case (ins.op)
      INC_SKIP_ZERO_OP, OR_FILE_REG_OP:
      begin
        e.fw = ins.dest ? mies_file_wr_type'{1'b1, ins.file_addr, r} : '0;
        e.acc = ins.dest ? acc_m : r;
        e.skip = (ins.op == INC_SKIP_ZERO_OP) && (r == MIES_ZERO_BYTE);
        e.rdy = !e.skip;
        e.pc = pc_m + (e.skip ? MIES_PC_SKIP_STEP : MIES_PC_STEP);
        e.z = (ins.op == OR_FILE_REG_OP) ? (r == MIES_ZERO_BYTE) : z_m;
      end
      SOFT_INT_OP:
      begin
        e.push = 1'b1;
        e.sd = pc_m + MIES_PC_STEP;
        e.pc = MIES_INT_VECTOR;
        e.rdy = 1'b0;
      end
      OR_LITERAL_OP:
      begin
        e.acc = acc_m | ins.literal;
        e.z = (e.acc == MIES_ZERO_BYTE);
      end
      PAGE_STORE_OP: e.pw = mies_page_wr_type'{1'b1, ins.page_addr, acc_m};
      PAGE_LOAD_OP: e.acc = pd;
      LONG_JUMP_OP:
      begin
        e.pc = ins.target;
        e.rdy = 1'b0;
      end
      default: e.pc = pc_m + MIES_PC_STEP;
    endcase
    n = 0;
    // Junk offered while stalled must be ignored
    while (ready !== 1'b1 && n < 10)
    begin
      instr_valid = 1'b1;
      instr = mies_instr_type'(33'({$urandom(), $urandom()}));
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 10)
    begin
      n_fail++;
      test_done();
    end
    instr_valid = 1'b1;
    instr = ins;
    file_rdata = fd;
    page_rdata = pd;
    exp_q.push_back(e);
    acc_m = e.acc;
    z_m = e.z;
    pc_m = e.pc;
    @(posedge mclk);
    #1;
  endtask

  function automatic mies_instr_type mk(input mies_op_type op, input logic [7:0] lit,
    input logic d, input logic [10:0] tgt);
    mk = '{op, lit, 6'h2A, d, 4'hF, tgt};
  endfunction

  // ------------------------------------------------------------
  // Monitor: compares each result with the oldest note
  // ------------------------------------------------------------
  initial
  begin
    forever
    begin
      @(negedge mclk);
      tk = !rst && instr_valid === 1'b1 && ready === 1'b1;
      @(posedge mclk);
      #2;
      if (tk && exp_q.size() > 0)
      begin
        w = exp_q.pop_front();
        chk("acc", 16'(acc), 16'(w.acc));
        chk("zero", 16'(zero), 16'(w.z));
        chk("pc", 16'(pc), 16'(w.pc));
        chk("ready", 16'(ready), 16'(w.rdy));
        chk("skip", 16'(skip), 16'(w.skip));
        chk("push", 16'(stack_push), 16'(w.push));
        chk("stack", 16'(stack_push ? stack_data : 11'h000), 16'(w.sd));
        chk("file_wr", 16'(file_wr.we ? file_wr : '0), 16'(w.fw));
        chk("page_wr", 16'(page_wr.we ? page_wr : '0), 16'(w.pw));
      end
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    file_rdata = 8'h00;
    page_rdata = 8'h00;
    acc_m = MIES_ACC_RESET;
    z_m = MIES_ZERO_RESET;
    pc_m = MIES_PC_RESET;
    void'($urandom(32'h1EE73ED1));
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    exec(mk(OR_LITERAL_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(OR_LITERAL_OP, 8'h50, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(PAGE_STORE_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(PAGE_LOAD_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h55);
    exec(mk(OR_FILE_REG_OP, 8'h00, 1'b1, 11'h000), 8'hAA, 8'h00);
    exec(mk(INC_SKIP_ZERO_OP, 8'h00, 1'b1, 11'h000), 8'hFF, 8'h00);
    exec(mk(INC_SKIP_ZERO_OP, 8'h00, 1'b0, 11'h000), 8'hFF, 8'h00);
    exec(mk(OR_FILE_REG_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(INC_SKIP_ZERO_OP, 8'h00, 1'b0, 11'h000), 8'h10, 8'h00);
    exec(mk(SOFT_INT_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(LONG_JUMP_OP, 8'h00, 1'b0, 11'h7FF), 8'h00, 8'h00);
    exec(mk(LONG_JUMP_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    exec(mk(NOP_OP, 8'h00, 1'b0, 11'h000), 8'h00, 8'h00);
    $display("directed test done");
    repeat (400)
      exec(mies_instr_type'(33'({$urandom(), $urandom()})),
        ($urandom() % 4 == 0) ? 8'hFF : 8'($urandom()), 8'($urandom()));
    instr_valid = 1'b0;
    repeat (4) @(posedge mclk);
    $display("random test done");
    test_done();
  end
endmodule
